// file: pkg/dms_regs.svh
// Constants of the audio core memory and safeload block: map, widths, counts.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef DMS_REGS_SVH
`define DMS_REGS_SVH

// ************************************************************
// Word formats
// ************************************************************
`define DMS_AUDIO_W 24
`define DMS_WORD_W 28
`define DMS_FRAC_W 23
`define DMS_ACC_W 56
`define DMS_PROG_W 40
`define DMS_PARAM_W 32
`define DMS_ADDR_W 11
`define DMS_SAT_POS 24'h7fffff
`define DMS_SAT_NEG 24'h800000
`define DMS_PARAM_UNITY 32'h00800000

// ************************************************************
// Memory map
// ************************************************************
`define DMS_PARAM_DEPTH 1024
`define DMS_PROG_DEPTH 512
`define DMS_PARAM_BASE 11'h000
`define DMS_PARAM_LAST 11'h3ff
`define DMS_PROG_BASE 11'h400
`define DMS_PROG_LAST 11'h5ff
`define DMS_RSVD_BASE 11'h600

// ************************************************************
// Sequencing counts
// ************************************************************
`define DMS_PC_LAST_FULL 9'h1ff
`define DMS_PC_LAST_HALF 9'h0ff
`define DMS_PC_LAST_QUAD 9'h07f
`define DMS_SL_SLOTS 5
`define DMS_SL_LAST 3'h4
`define DMS_INIT_LAST 10'h3ff
`define DMS_FIFO_DEPTH 16

`endif

// file: pkg/dms_pkg.sv
// Types shared by the audio core memory and safeload block.
// Assumes nothing of its surroundings.
package dms_pkg;
  // Sequencer states of the core
  typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_SAFELOAD, ST_RUN} dms_state_t;
  // Instruction opcodes, top nibble of a program word
  typedef enum logic [3:0] {OP_NOP, OP_LDIN, OP_MUL, OP_MAC, OP_LDACC, OP_OUT, OP_CLR} dms_op_t;
endpackage

// file: verilog/dms_fifo.sv
// Sample FIFO with valid/ready on both sides.
// Assumes one clock and an async active-low reset; D is a power of two.
`timescale 1ns/1ps
module dms_fifo #(
  parameter int W = 24,
  parameter int D = 16
) (
  input wire logic clk_in, // Clock
  input wire logic rst_n_in, // Async reset, active low
  input wire logic in_valid_in, // Writer offers a word
  input wire logic [W-1:0] in_data_in, // Word offered
  output logic in_ready_out, // Room for a word, registered
  output logic out_valid_out, // A word is waiting
  output logic [W-1:0] out_data_out, // Oldest word
  input wire logic out_ready_in // Reader takes the word
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D]; // Storage
  logic [AW-1:0] wr_q, wr_d; // Write pointer
  logic [AW-1:0] rd_q, rd_d; // Read pointer
  logic [AW:0] cnt_q, cnt_d; // Fill level
  logic rdy_q, rdy_d; // Registered not-full
  logic push, pop;

  assign push = in_valid_in & rdy_q;
  assign pop = out_valid_out & out_ready_in;
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out = mem[rd_q];
  assign in_ready_out = rdy_q;

  // ************************************************************
  // Pointer and level update
  // ************************************************************
  always_comb begin
    wr_d = push ? AW'(wr_q + 1'b1) : wr_q;
    rd_d = pop ? AW'(rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = (AW+1)'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = (AW+1)'(cnt_q - 1'b1);
    end
    // Ready looks ahead so the writer sees full on the same edge
    rdy_d = (cnt_d != (AW+1)'(D));
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b1;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
    end
  end

  // Storage has no reset; empty words are never read
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_q] <= in_data_in;
    end
  end
endmodule

// file: verilog/dms_clip.sv
// Saturating clipper from the 5.23 core word to a 1.23 output word.
// Assumes a twos complement input; purely combinational.
`timescale 1ns/1ps
`include "dms_regs.svh"
module dms_clip (
  input wire logic [`DMS_WORD_W-1:0] word_in, // Core word, 5.23
  output logic [`DMS_AUDIO_W-1:0] clip_out // Clipped word, 1.23
);
  // Top five bits all equal means the value already fits
  always_comb begin
    if (word_in[`DMS_WORD_W-1:`DMS_AUDIO_W-1] == {5{word_in[`DMS_WORD_W-1]}}) begin
      clip_out = word_in[`DMS_AUDIO_W-1:0];
    end else if (word_in[`DMS_WORD_W-1]) begin
      clip_out = `DMS_SAT_NEG;
    end else begin
      clip_out = `DMS_SAT_POS;
    end
  end
endmodule

// file: verilog/dms_core.sv
// Audio core sequencer with parameter and program memory, direct and safeload writes.
// Assumes host ports synchronous to CLK_SYS_IN and one sample per frame from the FIFO.
// Operation
// RULE1: Products and accumulator are 56 bits wide
// RULE2: Four headroom bits above 24-bit audio
// RULE3: Input samples sign-extended to 28 bits
// RULE4: Words are twos complement 5.23
// RULE5: Output saturates to 24 bits, +-1.0
// RULE6: Every instruction runs once per sample
// RULE7: Fewer instructions allow double or quad rate
// RULE8: Parameter memory 1024x32 at 0x000-0x3ff
// RULE9: Program memory 512x40, direct writes only
// RULE10: 0x600-0x7ff reserved, writes ignored
// RULE11: Parameters carry four zero top bits
// RULE12: Unity gain is 0x00800000
// RULE13: Everything zero after reset except program
// RULE14: Memories initialised from boot contents
// RULE15: Default program passes input, outputs muted
// RULE16: Direct parameter write steals core access
// RULE17: Host keeps clear bit low when loading
// RULE18: Five slots committed when core idle
// RULE19: Safeload writes parameter memory only
// RULE20: Burst address increments across regions
// RULE21: Slot address is 10-bit word index
// RULE22: All slots commit in one frame gap
`timescale 1ns/1ps
`include "dms_regs.svh"
module dms_core (
  input wire logic CLK_SYS_IN, // System clock, 10 MHz
  input wire logic RESET_N_IN, // Async reset, active low
  input wire logic REGS_ACTIVE_IN, // Clear-registers bit, low holds working register, accumulator and output at zero
  input wire logic [1:0] IPS_SEL_IN, // 0 full, 1 half, 2 or 3 quarter instruction count
  input wire logic AUD_IN_VALID_IN, // Input sample offered
  input wire logic [`DMS_AUDIO_W-1:0] AUD_IN_DATA_IN, // Input sample, 1.23
  output logic AUD_IN_READY_OUT, // FIFO has room
  output logic AUD_OUT_VALID_OUT, // Frame done pulse
  output logic [`DMS_AUDIO_W-1:0] AUD_OUT_DATA_OUT, // Clipped output sample
  input wire logic WR_EN_IN, // Direct write strobe
  input wire logic WR_BURST_IN, // Use incremented address instead of WR_ADDR_IN
  input wire logic [`DMS_ADDR_W-1:0] WR_ADDR_IN, // Direct write address
  input wire logic [`DMS_PROG_W-1:0] WR_DATA_IN, // Direct write data
  input wire logic RD_EN_IN, // Read strobe
  input wire logic [`DMS_ADDR_W-1:0] RD_ADDR_IN, // Read address
  output logic [`DMS_PROG_W-1:0] RD_DATA_OUT, // Read data
  output logic RD_VALID_OUT, // Read data pulse
  input wire logic SL_WR_IN, // Safeload slot write strobe
  input wire logic SL_ADDR_SEL_IN, // High writes slot address, low slot data
  input wire logic [2:0] SL_SLOT_IN, // Slot number 0 to 4
  input wire logic [`DMS_PARAM_W-1:0] SL_DATA_IN, // Slot address or data
  input wire logic SL_COMMIT_IN, // Request transfer of loaded slots
  output logic SL_BUSY_OUT, // Transfer pending
  output logic INIT_BUSY_OUT // Boot initialisation running
);

  // ************************************************************
  // Storage and state
  // ************************************************************
  logic [`DMS_PROG_W-1:0] prog_mem [`DMS_PROG_DEPTH]; // Program words
  logic [`DMS_PARAM_W-1:0] param_mem [`DMS_PARAM_DEPTH]; // Parameter words
  dms_pkg::dms_state_t state_q, state_d; // Sequencer state
  logic [8:0] pc_q, pc_d; // Instruction counter
  logic [9:0] init_q, init_d; // Boot fill index
  logic [2:0] sl_idx_q, sl_idx_d; // Slot being transferred
  logic sl_pend_q, sl_pend_d; // Commit requested
  logic signed [`DMS_WORD_W-1:0] x_q, x_d; // Working register, 5.23
  logic signed [`DMS_ACC_W-1:0] acc_q, acc_d; // Double precision accumulator
  logic [`DMS_WORD_W-1:0] smp_q, smp_d; // Current frame input
  logic [`DMS_AUDIO_W-1:0] out_q, out_d; // Output sample
  logic ovld_q, ovld_d; // Frame done
  logic [`DMS_ADDR_W-1:0] burst_q, burst_d; // Next burst address
  logic [`DMS_PROG_W-1:0] rd_q, rd_d; // Read data
  logic rvld_q; // Read valid
  logic init_busy_q; // Boot fill flag, kept in a flop so the port is glitch free
  logic [9:0] sl_adr_q [`DMS_SL_SLOTS]; // Slot word index
  logic [9:0] sl_adr_d [`DMS_SL_SLOTS];
  logic [`DMS_WORD_W-1:0] sl_dat_q [`DMS_SL_SLOTS]; // Slot data
  logic [`DMS_WORD_W-1:0] sl_dat_d [`DMS_SL_SLOTS];
  logic [`DMS_SL_SLOTS-1:0] sl_vld_q, sl_vld_d; // Slot holds an address

  // ************************************************************
  // Datapath wires
  // ************************************************************
  logic fifo_vld, fifo_pop, fifo_rdy;
  logic [`DMS_AUDIO_W-1:0] fifo_data;
  logic [`DMS_PROG_W-1:0] instr; // Current instruction
  dms_pkg::dms_op_t opc;
  logic [`DMS_PARAM_W-1:0] param_rd; // Coefficient seen by the core
  logic signed [`DMS_WORD_W-1:0] coef;
  logic signed [`DMS_ACC_W-1:0] prod; // Full 56-bit product
  logic [`DMS_AUDIO_W-1:0] clip_val;
  logic [8:0] pc_last; // Last instruction of a frame
  logic wr_ok, host_param_wr, host_prog_wr, sl_wr_go;
  logic [`DMS_ADDR_W-1:0] eff_addr, prog_off, rd_off;

  // Input samples queue here while a frame runs
  dms_fifo #(.W(`DMS_AUDIO_W), .D(`DMS_FIFO_DEPTH)) u_fifo (
    .clk_in(CLK_SYS_IN),
    .rst_n_in(RESET_N_IN),
    .in_valid_in(AUD_IN_VALID_IN),
    .in_data_in(AUD_IN_DATA_IN),
    .in_ready_out(fifo_rdy),
    .out_valid_out(fifo_vld),
    .out_data_out(fifo_data),
    .out_ready_in(fifo_pop)
  );

  // Saturation stage ahead of the outputs
  dms_clip u_clip (
    .word_in(x_q),
    .clip_out(clip_val) // RULE5
  );

  // Boot program: take the input, send it out, idle the rest
  function automatic logic [`DMS_PROG_W-1:0] boot_prog(input logic [8:0] idx);
    logic [`DMS_PROG_W-1:0] w;
    w = '0;
    if (idx == 9'h000) begin
      w = {dms_pkg::OP_LDIN, 36'h0};
    end else if (idx == 9'h001) begin
      w = {dms_pkg::OP_OUT, 36'h0};
    end
    return w;
  endfunction

  // ************************************************************
  // Address decode and host access
  // ************************************************************
  assign wr_ok = WR_EN_IN && (state_q != dms_pkg::ST_INIT);
  assign eff_addr = WR_BURST_IN ? burst_q : WR_ADDR_IN;
  assign prog_off = eff_addr - `DMS_PROG_BASE;
  assign rd_off = RD_ADDR_IN - `DMS_PROG_BASE;
  assign host_param_wr = wr_ok && (eff_addr <= `DMS_PARAM_LAST); // RULE8
  assign host_prog_wr = wr_ok && (eff_addr >= `DMS_PROG_BASE) && (eff_addr <= `DMS_PROG_LAST); // RULE9 RULE10
  // Burst steps on through every region and wraps the 11-bit space
  assign burst_d = wr_ok ? `DMS_ADDR_W'(eff_addr + 1'b1) : burst_q; // RULE20

  // Instruction fetch; a direct parameter write blanks the core's view
  assign instr = prog_mem[pc_q];
  assign opc = dms_pkg::dms_op_t'(instr[`DMS_PROG_W-1:`DMS_PROG_W-4]);
  assign param_rd = host_param_wr ? '0 : param_mem[instr[9:0]]; // RULE16
  assign coef = param_rd[`DMS_WORD_W-1:0]; // RULE4 RULE12
  assign prod = x_q * coef; // RULE1

  // Safeload only fills the parameter array, and yields to direct parameter writes
  assign sl_wr_go = (state_q == dms_pkg::ST_SAFELOAD) && !host_param_wr && sl_vld_q[sl_idx_q]; // RULE19

  // Instruction count per frame
  always_comb begin
    unique case (IPS_SEL_IN)
      2'h0: pc_last = `DMS_PC_LAST_FULL; // RULE6
      2'h1: pc_last = `DMS_PC_LAST_HALF; // RULE7
      default: pc_last = `DMS_PC_LAST_QUAD; // RULE7
    endcase
  end

  // ************************************************************
  // Sequencer and datapath
  // ************************************************************
  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    init_d = init_q;
    sl_idx_d = sl_idx_q;
    x_d = x_q;
    acc_d = acc_q;
    smp_d = smp_q;
    out_d = out_q;
    ovld_d = 1'b0;
    fifo_pop = 1'b0;
    unique case (state_q)
      dms_pkg::ST_INIT: begin
        // One word per cycle from the boot contents
        init_d = 10'(init_q + 1'b1); // RULE14
        if (init_q == `DMS_INIT_LAST) begin
          state_d = dms_pkg::ST_IDLE;
        end
      end
      dms_pkg::ST_IDLE: begin
        if (sl_pend_q) begin
          // Frame gap: move the slots before the next sample
          state_d = dms_pkg::ST_SAFELOAD; // RULE18
          sl_idx_d = 3'h0;
        end else if (fifo_vld) begin
          fifo_pop = 1'b1;
          smp_d = {{(`DMS_WORD_W-`DMS_AUDIO_W){fifo_data[`DMS_AUDIO_W-1]}}, fifo_data}; // RULE3 RULE2
          pc_d = 9'h000;
          state_d = dms_pkg::ST_RUN;
        end
      end
      dms_pkg::ST_SAFELOAD: begin
        // A direct parameter write holds the walk for that cycle
        if (!host_param_wr) begin
          sl_idx_d = 3'(sl_idx_q + 1'b1);
          if (sl_idx_q == `DMS_SL_LAST) begin
            state_d = dms_pkg::ST_IDLE; // RULE22
          end
        end
      end
      dms_pkg::ST_RUN: begin
        unique case (opc)
          dms_pkg::OP_NOP: ;
          dms_pkg::OP_LDIN: x_d = smp_q;
          dms_pkg::OP_MUL: acc_d = prod; // RULE1
          dms_pkg::OP_MAC: acc_d = `DMS_ACC_W'(acc_q + prod); // RULE1
          dms_pkg::OP_LDACC: x_d = acc_q[`DMS_FRAC_W+`DMS_WORD_W-1:`DMS_FRAC_W]; // RULE4
          dms_pkg::OP_OUT: out_d = clip_val; // RULE5
          dms_pkg::OP_CLR: acc_d = '0;
          default: ; // Undefined opcodes act as no-ops
        endcase
        pc_d = 9'(pc_q + 1'b1);
        if (pc_q == pc_last) begin
          state_d = dms_pkg::ST_IDLE; // RULE6
          ovld_d = 1'b1;
        end
      end
    endcase
    // Clear bit low keeps the core silent: outputs muted until host enables
    if (!REGS_ACTIVE_IN) begin
      x_d = '0; // RULE15
      acc_d = '0;
      out_d = '0;
    end
  end

  // ************************************************************
  // Safeload slots and commit flag
  // ************************************************************
  always_comb begin
    sl_vld_d = sl_vld_q;
    for (int i = 0; i < `DMS_SL_SLOTS; i++) begin
      sl_adr_d[i] = sl_adr_q[i];
      sl_dat_d[i] = sl_dat_q[i];
      if ((state_q == dms_pkg::ST_SAFELOAD) && !host_param_wr && (sl_idx_q == 3'(i))) begin
        sl_vld_d[i] = 1'b0;
      end
      // A new address load in the same cycle wins over the transfer clear
      if (SL_WR_IN && (SL_SLOT_IN == 3'(i))) begin
        if (SL_ADDR_SEL_IN) begin
          sl_adr_d[i] = SL_DATA_IN[9:0]; // RULE21
          sl_vld_d[i] = 1'b1;
        end else begin
          sl_dat_d[i] = SL_DATA_IN[`DMS_WORD_W-1:0]; // RULE11
        end
      end
    end
    sl_pend_d = SL_COMMIT_IN || (sl_pend_q && !((state_q == dms_pkg::ST_SAFELOAD) && !host_param_wr
                && (sl_idx_q == `DMS_SL_LAST)));
  end

  // Host read answer, one cycle after the strobe
  always_comb begin
    rd_d = rd_q;
    if (RD_EN_IN) begin
      if (RD_ADDR_IN <= `DMS_PARAM_LAST) begin
        rd_d = {8'h00, param_mem[RD_ADDR_IN[9:0]]}; // RULE11
      end else if (RD_ADDR_IN <= `DMS_PROG_LAST) begin
        rd_d = prog_mem[rd_off[8:0]]; // RULE9
      end else begin
        rd_d = '0; // RULE10
      end
    end
  end

  // ************************************************************
  // State registers
  // ************************************************************
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_q <= dms_pkg::ST_INIT; // RULE13
      pc_q <= '0;
      init_q <= '0;
      sl_idx_q <= '0;
      sl_pend_q <= 1'b0;
      x_q <= '0;
      acc_q <= '0;
      smp_q <= '0;
      out_q <= '0;
      ovld_q <= 1'b0;
      burst_q <= '0;
      rd_q <= '0;
      rvld_q <= 1'b0;
      init_busy_q <= 1'b1;
      sl_vld_q <= '0;
      for (int i = 0; i < `DMS_SL_SLOTS; i++) begin
        sl_adr_q[i] <= '0;
        sl_dat_q[i] <= '0;
      end
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      init_q <= init_d;
      sl_idx_q <= sl_idx_d;
      sl_pend_q <= sl_pend_d;
      x_q <= x_d;
      acc_q <= acc_d;
      smp_q <= smp_d;
      out_q <= out_d;
      ovld_q <= ovld_d;
      burst_q <= burst_d;
      rd_q <= rd_d;
      rvld_q <= RD_EN_IN;
      init_busy_q <= (state_d == dms_pkg::ST_INIT);
      sl_vld_q <= sl_vld_d;
      sl_adr_q <= sl_adr_d;
      sl_dat_q <= sl_dat_d;
    end
  end

  // Memory arrays; reset contents come from the boot fill, not the reset
  always_ff @(posedge CLK_SYS_IN) begin
    if (state_q == dms_pkg::ST_INIT) begin
      param_mem[init_q] <= '0; // RULE14 RULE13
      if (!init_q[9]) begin
        prog_mem[init_q[8:0]] <= boot_prog(init_q[8:0]); // RULE15
      end
    end else begin
      if (host_param_wr) begin
        param_mem[eff_addr[9:0]] <= {4'h0, WR_DATA_IN[`DMS_WORD_W-1:0]}; // RULE16 RULE11
      end else if (sl_wr_go) begin
        param_mem[sl_adr_q[sl_idx_q]] <= {4'h0, sl_dat_q[sl_idx_q]}; // RULE18
      end
      if (host_prog_wr) begin
        prog_mem[prog_off[8:0]] <= WR_DATA_IN; // RULE9
      end
    end
  end

  assign AUD_IN_READY_OUT = fifo_rdy;
  assign AUD_OUT_VALID_OUT = ovld_q;
  assign AUD_OUT_DATA_OUT = out_q;
  assign RD_DATA_OUT = rd_q;
  assign RD_VALID_OUT = rvld_q;
  assign SL_BUSY_OUT = sl_pend_q;
  assign INIT_BUSY_OUT = init_busy_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESET_N_IN);

  sequence s_sl_enter;
    (state_q == dms_pkg::ST_IDLE) && sl_pend_q;
  endsequence
  sequence s_sl_quiet;
    (!WR_EN_IN && !SL_WR_IN)[*5];
  endsequence

  sign_extend_a: assert property (fifo_pop |=> smp_q[27:24] == {4{smp_q[23]}} && smp_q[23:0] == $past(fifo_data)) // RULE3
    else $error("input sample not sign extended");
  frame_len_a: assert property (ovld_q |-> $past(pc_q) == $past(pc_last) && $past(state_q) == dms_pkg::ST_RUN) // RULE6
    else $error("frame ended at wrong instruction");
  clip_pos_a: assert property ((state_q == dms_pkg::ST_RUN) && (opc == dms_pkg::OP_OUT) && REGS_ACTIVE_IN // RULE5
    && !x_q[27] && (x_q[26:23] != 4'h0) |=> out_q == `DMS_SAT_POS)
    else $error("positive overflow not saturated");
  out_mute_a: assert property (!REGS_ACTIVE_IN |=> out_q == '0 && acc_q == '0) // RULE15
    else $error("output not muted while clear bit low");
  unity_gain_a: assert property ((state_q == dms_pkg::ST_RUN) && (opc == dms_pkg::OP_MUL) && REGS_ACTIVE_IN // RULE12
    && (param_rd == `DMS_PARAM_UNITY) |=> acc_q[50:23] == $past(x_q))
    else $error("unity coefficient changed the sample");
  rsvd_read_a: assert property (RD_EN_IN && (RD_ADDR_IN >= `DMS_RSVD_BASE) |=> RD_VALID_OUT && RD_DATA_OUT == '0) // RULE10
    else $error("reserved read returned data");
  param_pad_a: assert property (RD_EN_IN && (RD_ADDR_IN <= `DMS_PARAM_LAST) |=> RD_DATA_OUT[39:28] == '0) // RULE11
    else $error("parameter read has nonzero top bits");
  burst_step_a: assert property (wr_ok |=> burst_q == `DMS_ADDR_W'($past(eff_addr) + 1'b1)) // RULE20
    else $error("burst address did not advance");
  init_len_a: assert property ((state_q == dms_pkg::ST_INIT) && (init_q != `DMS_INIT_LAST) |=> state_q == dms_pkg::ST_INIT) // RULE14
    else $error("boot fill ended early");
  sl_frame_a: assert property (s_sl_enter ##1 s_sl_quiet |=> state_q == dms_pkg::ST_IDLE && sl_vld_q == '0) // RULE22
    else $error("safeload did not finish in one gap");
endmodule

// file: tb/dms_host.sv
// Control-side model: direct writes, reads and safeload slot loads into the audio core.
// Assumes one system clock; requests change 1 ns after a rising edge and hold to the taking edge.
`timescale 1ns/1ps
module dms_host (
  input wire logic clk_in, // System clock
  input wire logic rd_valid_in, // Read data pulse
  input wire logic [39:0] rd_data_in, // Read data
  output logic wr_en_out, // Write strobe
  output logic wr_burst_out, // Burst address select
  output logic [10:0] wr_addr_out, // Write address
  output logic [39:0] wr_data_out, // Write data
  output logic rd_en_out, // Read strobe
  output logic [10:0] rd_addr_out, // Read address
  output logic sl_wr_out, // Slot write strobe
  output logic sl_sel_out, // Slot address select
  output logic [2:0] sl_slot_out, // Slot number
  output logic [31:0] sl_data_out, // Slot payload
  output logic sl_commit_out // Commit pulse
);
  // Quiet bus at time zero
  initial begin
    {wr_en_out, wr_burst_out, wr_addr_out, wr_data_out, rd_en_out, rd_addr_out} = '0;
    {sl_wr_out, sl_sel_out, sl_slot_out, sl_data_out, sl_commit_out} = '0;
  end

  // One write; released lines show the inverse so stale data never looks valid
  task automatic wr(input logic [10:0] a, input logic [39:0] d, input logic b);
    @(posedge clk_in) #1;
    {wr_en_out, wr_burst_out, wr_addr_out, wr_data_out} = {1'b1, b, a, d};
    @(posedge clk_in) #1;
    {wr_en_out, wr_burst_out, wr_addr_out, wr_data_out} = {2'b00, ~a, ~d};
  endtask

  // One read; data and valid taken one edge after the strobe
  task automatic rd(input logic [10:0] a, output logic [39:0] d, output logic v);
    @(posedge clk_in) #1;
    {rd_en_out, rd_addr_out} = {1'b1, a};
    @(posedge clk_in) #1;
    {v, d} = {rd_valid_in, rd_data_in};
    {rd_en_out, rd_addr_out} = {1'b0, ~a};
  endtask

  // Slot load, or commit alone when c is high
  task automatic sl(input logic s, input logic [2:0] n, input logic [31:0] d, input logic c);
    @(posedge clk_in) #1;
    {sl_wr_out, sl_sel_out, sl_slot_out, sl_data_out, sl_commit_out} = {~c, s, n, d, c};
    @(posedge clk_in) #1;
    {sl_wr_out, sl_sel_out, sl_slot_out, sl_data_out, sl_commit_out} = {1'b0, ~s, ~n, ~d, 1'b0};
  endtask
endmodule

// file: tb/tb_top.sv
// Self-checking bench of the audio core: memories, safeload, frames and sample FIFO.
// Assumes dms_core as design top and dms_host as the control side.
`timescale 1ns/1ps
`include "dms_regs.svh"
module tb_top;
  // ************************************************************
  // Signals and instances
  // ************************************************************
  logic clk = 0, rst_n = 0, act = 0, a_vld = 0, full = 0; // Clock, reset, unmute, valid, FIFO seen full
  logic [1:0] ips = 0; // Instruction count select
  logic [23:0] a_dat = 0, o_dat, v; // Samples
  logic a_rdy, o_vld, rd_v, wr_en, wr_b, rd_en, sl_wr, sl_sel, sl_c, sl_busy, init_busy, ok;
  logic [10:0] wr_a, rd_a, a; // Addresses
  logic [39:0] wr_d, rd_d, d, p; // Memory words
  logic [2:0] sl_n; // Slot number
  logic [31:0] sl_d; // Slot payload
  logic [27:0] sd [5]; // Safeload values
  logic [23:0] q [$]; // Samples in flight
  int n_errors = 0, checks_done = 0, k;

  dms_core uut (.CLK_SYS_IN(clk), .RESET_N_IN(rst_n), .REGS_ACTIVE_IN(act), .IPS_SEL_IN(ips),
    .AUD_IN_VALID_IN(a_vld), .AUD_IN_DATA_IN(a_dat), .AUD_IN_READY_OUT(a_rdy), .AUD_OUT_VALID_OUT(o_vld),
    .AUD_OUT_DATA_OUT(o_dat), .WR_EN_IN(wr_en), .WR_BURST_IN(wr_b), .WR_ADDR_IN(wr_a), .WR_DATA_IN(wr_d),
    .RD_EN_IN(rd_en), .RD_ADDR_IN(rd_a), .RD_DATA_OUT(rd_d), .RD_VALID_OUT(rd_v), .SL_WR_IN(sl_wr),
    .SL_ADDR_SEL_IN(sl_sel), .SL_SLOT_IN(sl_n), .SL_DATA_IN(sl_d), .SL_COMMIT_IN(sl_c),
    .SL_BUSY_OUT(sl_busy), .INIT_BUSY_OUT(init_busy));
  dms_host host (.clk_in(clk), .rd_valid_in(rd_v), .rd_data_in(rd_d), .wr_en_out(wr_en), .wr_burst_out(wr_b),
    .wr_addr_out(wr_a), .wr_data_out(wr_d), .rd_en_out(rd_en), .rd_addr_out(rd_a), .sl_wr_out(sl_wr),
    .sl_sel_out(sl_sel), .sl_slot_out(sl_n), .sl_data_out(sl_d), .sl_commit_out(sl_c));

  // 100 ns system clock
  always #50 clk = ~clk;

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic end_of_test();
    if (n_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Case-equal compare, so unknowns never match
  task automatic chk(input string w, input logic [39:0] e, input logic [39:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask

  // Spent wait bound ends the run
  task automatic fail(input string w);
    n_errors++;
    $display("unexpected %s: expected done seen pending", w);
    end_of_test();
  endtask

  // Offer a sample, held until ready lets the edge take it
  task automatic push(input logic [23:0] s);
    int i;
    @(posedge clk) #1;
    {a_vld, a_dat} = {1'b1, s};
    for (i = 0; i < 3000 && a_rdy !== 1; i++) @(posedge clk) #1;
    if (a_rdy !== 1) fail("input ready");
    if (i > 0) full = 1;
    q.push_back(s);
    @(posedge clk) #1;
    {a_vld, a_dat} = {1'b0, ~s};
  endtask

  // Edges until the frame-done pulse
  task automatic wait_out(output int n);
    for (n = 1; n < 3000; n++) begin
      @(posedge clk) #1;
      if (o_vld === 1) return;
    end
    fail("output pulse");
  endtask

  task automatic rdchk(input logic [10:0] ad, input logic [39:0] e);
    host.rd(ad, d, ok);
    chk("read valid", 40'h1, 40'(ok));
    chk("read data", e, d);
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    void'($urandom(36));
    repeat (20) @(posedge clk);
    #1 rst_n = 1;
    for (k = 0; k < 1100 && init_busy !== 0; k++) @(posedge clk) #1;
    if (init_busy !== 0) fail("boot fill");
    // Boot contents: default program, zero parameters, empty reserved space
    for (int i = 0; i < 2; i++) begin
      host.rd(11'h400 + 11'(i), d, ok);
      chk("default opcode", 40'(i == 0 ? 1 : 5), 40'(d[39:36]));
    end
    rdchk(11'($urandom_range(1023)), 40'h0);
    rdchk(11'h600 + 11'($urandom_range(511)), 40'h0);
    // Muted at power-up, then passthrough at every instruction count
    push(24'($urandom));
    wait_out(k);
    chk("muted sample", 40'h0, 40'(o_dat));
    act = 1;
    for (int s = 0; s < 4; s++) begin
      ips = 2'(s);
      v = 24'($urandom);
      push(v);
      wait_out(k);
      chk("frame length", 40'(s == 0 ? 513 : s == 1 ? 257 : 129), 40'(k));
      chk("passed sample", 40'(v), 40'(o_dat));
    end
    // Fill the FIFO until it refuses while the core drains slowly
    q.delete();
    fork
      for (int i = 0; i < 20; i++) push(i == 0 ? 24'h7fffff : i == 1 ? 24'h800000 : 24'($urandom));
      for (int i = 0; i < 20; i++) begin
        wait_out(k);
        chk("drained sample", 40'(q.pop_front()), 40'(o_dat));
      end
    join
    chk("fifo refused", 40'h1, 40'(full));
    // Direct writes with the core muted, burst across the region boundary
    act = 0;
    a = 11'($urandom_range(1022));
    p = {8'($urandom), $urandom};
    host.wr(a, {12'h000, p[27:0]}, 1'b0);
    rdchk(a, {12'h000, p[27:0]});
    host.wr(11'h3ff, {8'h00, `DMS_PARAM_UNITY}, 1'b0);
    host.wr(11'h000, p, 1'b1);
    rdchk(11'h3ff, {8'h00, `DMS_PARAM_UNITY});
    rdchk(11'h400, p);
    a = 11'h600 + 11'($urandom_range(511));
    host.wr(a, ~p, 1'b0);
    rdchk(a, 40'h0);
    // All five safeload slots committed in one gap
    a = 11'($urandom_range(1018));
    for (int i = 0; i < 5; i++) begin
      sd[i] = 28'($urandom);
      host.sl(1'b1, 3'(i), {22'h0, a[9:0] + 10'(i)}, 1'b0);
      host.sl(1'b0, 3'(i), {4'h0, sd[i]}, 1'b0);
    end
    host.sl(1'b0, 3'h0, 32'h0, 1'b1);
    chk("safeload busy", 40'h1, 40'(sl_busy));
    for (k = 0; k < 50 && sl_busy !== 0; k++) @(posedge clk) #1;
    if (sl_busy !== 0) fail("safeload");
    chk("safeload cycles", 40'h1, 40'(k < 8));
    for (int i = 0; i < 5; i++) rdchk(a + 11'(i), {12'h0, sd[i]});
    rdchk(11'h400, p);
    // Gain of 8.0 on a half-scale sample must clip at the positive limit
    host.wr(11'h3fe, 40'h0004000000, 1'b0);
    host.wr(11'h400, {4'h1, 36'h0}, 1'b0);
    host.wr(11'h000, {4'h2, 26'h0, 10'h3fe}, 1'b1);
    host.wr(11'h000, {4'h4, 36'h0}, 1'b1);
    host.wr(11'h000, {4'h5, 36'h0}, 1'b1);
    act = 1;
    push(24'h400000);
    wait_out(k);
    chk("clipped sample", 40'(`DMS_SAT_POS), 40'(o_dat));
    end_of_test();
  end
endmodule
